// ===== bidc_defs.svh
// Constants for the boot image directory checker
// How it works
// - Only fetch from the top 16 MB, 0xFF00_0000 to 0xFFFF_FFFF.
// - The word at 0xFFFF_FFE8 is the platform firmware entry address.
// - The word at 0xFFFF_FFE0 is the primary directory table address.
// - Early processor entry lives at 0xFFFF_FFD0, outside the table checksum.
// - The word at 0xFFFF_FFC8 is the alternate table; zero means none.
// - Use the alternate table only when the primary checksum fails.
// - Firmware code areas are whole multiples of 16 bytes.
// - Flag a late processor firmware base not on a 32K boundary.
// - Protected region is early platform plus early processor size plus 64.
// - The table is a run of 16-byte entries with address and size.
// - Entry zero is the header, entry one the late processor firmware.
// - Type codes must not decrease; repeats are allowed.
// - Size field is 3 bytes, times 16 gives the byte length.
// - The late processor entry's 2-byte version is exposed unchanged.
// - Decode the 7-bit type; 0x02 to 0x0D are reserved.
// - Types 0x10 to 0x7E are vendor types and not errors.
// - A clear checksum-valid flag skips the component checksum.
// - With the flag set, component bytes plus checksum must sum to zero.
// - Header flag set means all table bytes must sum to zero.
// - The header address field must hold the table signature.
// - Reserved entry fields must be zero; nonzero is flagged.
// - A table checksum failure reports status code 2.
// - A missing late processor entry reports status code 6.
`ifndef BIDC_DEFS_SVH
`define BIDC_DEFS_SVH
`define BIDC_REGION_TOP   40'h00_0000_00FF
`define BIDC_REGION_SPAN  29'h100_0000
`define BIDC_PTR_BASE     32'hFFFF_FFC8
`define BIDC_PTR_BYTES    28'h000_0028
`define BIDC_ENT_BYTES    28'h000_0010
`define BIDC_SIG          64'h2020_205F_5449_465F
`define BIDC_T_HDR        7'h00
`define BIDC_T_LATE       7'h01
`define BIDC_T_RSV_LO     7'h02
`define BIDC_T_RSV_HI     7'h0D
`define BIDC_ALIGN_MSB    14
`define BIDC_PROT_EXTRA   32'h0000_0040
`define BIDC_C_OK         8'h00
`define BIDC_C_HDR        8'h01
`define BIDC_C_SUM        8'h02
`define BIDC_C_LATE_SUM   8'h03
`define BIDC_C_MISSING    8'h06
`define BIDC_C_UNALIGN    8'h08
`define BIDC_C_ORDER      8'h10
`define BIDC_C_RSVD       8'h11
`define BIDC_C_RANGE      8'h12
`define BIDC_C_KIND       8'h13
`define BIDC_REG_CTRL     8'h00
`define BIDC_REG_STATUS   8'h04
`define BIDC_REG_ENTRY    8'h08
`define BIDC_REG_TABLE    8'h0C
`define BIDC_REG_LBASE    8'h10
`define BIDC_REG_LLEN     8'h14
`define BIDC_REG_LVER     8'h18
`define BIDC_REG_PROT     8'h1C
`define BIDC_REG_COUNT    8'h20
`define BIDC_CTRL_START   0
`define BIDC_CTRL_CSUM    1
`define BIDC_RESP_OKAY    2'h0
`define BIDC_RESP_SLVERR  2'h2
`endif

// ===== bidc_pkg.sv
// Types shared by the directory checker modules
package bidc_pkg;
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h0,
    ST_PTRS  = 4'h1,
    ST_EVPTR = 4'h3,
    ST_ENT   = 4'h2,
    ST_EWAIT = 4'h6,
    ST_EVENT = 4'h7,
    ST_TSUM  = 4'h5,
    ST_COMP  = 4'h4,
    ST_DONE  = 4'hC
  } bidc_state_e;

  // Entry image, byte 0 in the low bits
  typedef struct packed {
    logic [7:0]  chk;
    logic        cv;
    logic [6:0]  kind;
    logic [15:0] version;
    logic [7:0]  rsvd;
    logic [23:0] size;
    logic [63:0] addr;
  } bidc_entry_s;

  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
  } bidc_rd_req_s;
endpackage : bidc_pkg

// ===== bidc_entry_dec.sv
`timescale 1ns/1ps
`include "bidc_defs.svh"
// Registered decoder for one 16-byte directory entry
module bidc_entry_dec
  import bidc_pkg::*;
(
  // Clock and reset
  input  logic         aclk,
  input  logic         aresetn,
  // Raw entry bytes
  input  logic [127:0] raw,
  // Decoded entry
  output bidc_entry_s  ent,
  output logic [27:0]  len,
  output logic         rsvd_bad,
  output logic         sig_ok,
  output logic         kind_bad
);
  bidc_entry_s e_w;

  assign e_w = bidc_entry_s'(raw);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ent      <= '0;
      len      <= 28'h000_0000;
      rsvd_bad <= 1'b0;
      sig_ok   <= 1'b0;
      kind_bad <= 1'b0;
    end else begin
      ent      <= e_w;
      len      <= {e_w.size, 4'h0};
      rsvd_bad <= (e_w.rsvd != 8'h00);
      sig_ok   <= (e_w.addr == `BIDC_SIG);
      kind_bad <= (e_w.kind >= `BIDC_T_RSV_LO) &&
                  (e_w.kind <= `BIDC_T_RSV_HI);
    end
  end
endmodule : bidc_entry_dec

// ===== bidc_top.sv
// The implementer's own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "bidc_defs.svh"
// Boot image directory checker with AXI4-Lite registers
module bidc_top
  import bidc_pkg::*;
(
  // Clock and reset
  input  logic         aclk,
  input  logic         aresetn,
  // AXI4-Lite write
  input  logic         s_axi_awvalid,
  output logic         s_axi_awready,
  input  logic [7:0]   s_axi_awaddr,
  input  logic         s_axi_wvalid,
  output logic         s_axi_wready,
  input  logic [31:0]  s_axi_wdata,
  input  logic [3:0]   s_axi_wstrb,
  output logic         s_axi_bvalid,
  input  logic         s_axi_bready,
  output logic [1:0]   s_axi_bresp,
  // AXI4-Lite read
  input  logic         s_axi_arvalid,
  output logic         s_axi_arready,
  input  logic [7:0]   s_axi_araddr,
  output logic         s_axi_rvalid,
  input  logic         s_axi_rready,
  output logic [31:0]  s_axi_rdata,
  output logic [1:0]   s_axi_rresp,
  // Firmware storage byte reads
  output bidc_rd_req_s stor_rd,
  input  logic         stor_ack,
  input  logic [7:0]   stor_data
);
  bidc_state_e  state_r;
  bidc_rd_req_s rd_r;
  logic [27:0]  cnt_r;
  logic [23:0]  idx_r;
  logic [23:0]  nent_r;
  logic [127:0] raw_r;
  logic [319:0] ptr_r;
  logic [7:0]   sum_r;
  logic [6:0]   prev_r;
  logic [7:0]   pend_r;
  logic         use_alt_r;
  logic         hdr_cv_r;
  bidc_entry_s  late_r;
  logic [27:0]  late_len_r;
  logic [31:0]  prot_r;
  logic         done_r;
  logic         err_r;
  logic [7:0]   code_r;
  logic         start_r;
  logic         csum_en_r;
  bidc_entry_s  dec_ent;
  logic [27:0]  dec_len;
  logic         dec_rsvd;
  logic         dec_sig;
  logic         dec_kind;
  bidc_entry_s  early_w;
  logic [63:0]  alt_w;
  logic [63:0]  tbl_w;
  logic         hdr_w;
  logic         fin_w;
  logic [7:0]   fin_code_w;
  logic         retry_w;
  logic         soft_w;
  logic [7:0]   scode_w;
  logic         sum_bad_w;
  logic         comp_go_w;
  logic         last_w;
  logic         aw_hold_r;
  logic         w_hold_r;
  logic [7:0]   awaddr_r;
  logic [31:0]  wdata_r;
  logic [3:0]   wstrb_r;
  logic         bvalid_r;
  logic [1:0]   bresp_r;
  logic         rvalid_r;
  logic [31:0]  rdata_r;
  logic [1:0]   rresp_r;

  // Start plus length lies wholly inside the firmware region
  function automatic logic in_reg(input logic [63:0] a,
                                  input logic [27:0] n);
    logic [28:0] e;
    e = {5'h00, a[23:0]} + {1'b0, n};
    return (a[63:24] == `BIDC_REGION_TOP) && (e <= `BIDC_REGION_SPAN);
  endfunction : in_reg

  bidc_entry_dec u_dec (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .raw      (raw_r),
    .ent      (dec_ent),
    .len      (dec_len),
    .rsvd_bad (dec_rsvd),
    .sig_ok   (dec_sig),
    .kind_bad (dec_kind)
  );

  assign alt_w   = ptr_r[63:0];
  assign early_w = bidc_entry_s'(ptr_r[191:64]);
  assign tbl_w   = use_alt_r ? alt_w : ptr_r[255:192];
  assign hdr_w   = (idx_r == 24'h00_0000);
  assign last_w  = !hdr_w && ((idx_r + 24'h00_0001) == nent_r);
  // table sum only when header asks
  assign sum_bad_w = hdr_cv_r && (sum_r != 8'h00);
  // component sum only with flag set
  assign comp_go_w = late_r.cv && csum_en_r && (late_len_r != 28'h0);
  assign stor_rd = rd_r;

  always_comb begin
    fin_w      = 1'b0;
    fin_code_w = `BIDC_C_OK;
    retry_w    = 1'b0;
    soft_w     = 1'b0;
    scode_w    = `BIDC_C_OK;
    case (state_r)
      ST_EVPTR: begin
        // table must start inside the region
        if (!in_reg(tbl_w, `BIDC_ENT_BYTES)) begin
          fin_w      = 1'b1;
          fin_code_w = `BIDC_C_RANGE;
        end
      end
      ST_EVENT: begin
        if (hdr_w) begin
          if (dec_ent.kind != `BIDC_T_HDR || !dec_sig) begin
            fin_w      = 1'b1;
            fin_code_w = `BIDC_C_HDR;
          end else if (dec_ent.size < 24'h00_0002) begin
            fin_w      = 1'b1;
            fin_code_w = `BIDC_C_MISSING;
          end else if (!in_reg(tbl_w, dec_len)) begin
            fin_w      = 1'b1;
            fin_code_w = `BIDC_C_RANGE;
          end
        end else if (idx_r == 24'h00_0001) begin
          // second entry must be late firmware
          if (dec_ent.kind != `BIDC_T_LATE) begin
            fin_w      = 1'b1;
            fin_code_w = `BIDC_C_MISSING;
          end else if (dec_ent.addr[`BIDC_ALIGN_MSB:0] != 15'h0000) begin
            fin_w      = 1'b1;
            fin_code_w = `BIDC_C_UNALIGN;
          end else if (!in_reg(dec_ent.addr, dec_len)) begin
            fin_w      = 1'b1;
            fin_code_w = `BIDC_C_RANGE;
          end
        end
        if (dec_rsvd) begin
          soft_w  = 1'b1;
          scode_w = `BIDC_C_RSVD;
        end else if (dec_ent.kind < prev_r) begin
          soft_w  = 1'b1;
          scode_w = `BIDC_C_ORDER;
        end else if (dec_kind) begin
          soft_w  = 1'b1;
          scode_w = `BIDC_C_KIND;
        end
      end
      ST_TSUM: begin
        if (sum_bad_w && !use_alt_r && alt_w != 64'h0) begin
          retry_w = 1'b1;
        end else if (sum_bad_w) begin
          fin_w      = 1'b1;
          fin_code_w = `BIDC_C_SUM;
        end else if (pend_r != `BIDC_C_OK || !comp_go_w) begin
          fin_w      = 1'b1;
          fin_code_w = pend_r;
        end
      end
      ST_COMP: begin
        if (stor_ack && cnt_r == 28'h000_0001) begin
          fin_w = 1'b1;
          if ((sum_r + stor_data) != 8'h00) begin
            fin_code_w = `BIDC_C_LATE_SUM;
          end
        end
      end
      default: fin_w = 1'b0;
    endcase
  end

  // Directory walk
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r    <= ST_IDLE;
      rd_r       <= '0;
      cnt_r      <= 28'h000_0000;
      idx_r      <= 24'h00_0000;
      nent_r     <= 24'h00_0000;
      raw_r      <= '0;
      ptr_r      <= '0;
      sum_r      <= 8'h00;
      prev_r     <= 7'h00;
      pend_r     <= `BIDC_C_OK;
      use_alt_r  <= 1'b0;
      hdr_cv_r   <= 1'b0;
      late_r     <= '0;
      late_len_r <= 28'h000_0000;
    end else begin
      case (state_r)
        ST_IDLE: begin
          // fetch starts in the pointer slots
          if (start_r) begin
            state_r <= ST_PTRS;
            rd_r    <= '{valid: 1'b1, addr: `BIDC_PTR_BASE};
            cnt_r   <= `BIDC_PTR_BYTES;
          end
        end
        ST_PTRS: begin
          if (stor_ack) begin
            ptr_r     <= {stor_data, ptr_r[319:8]};
            rd_r.addr <= rd_r.addr + 32'h0000_0001;
            cnt_r     <= cnt_r - 28'h000_0001;
            if (cnt_r == 28'h000_0001) begin
              rd_r.valid <= 1'b0;
              state_r    <= ST_EVPTR;
            end
          end
        end
        ST_EVPTR: begin
          if (fin_w) begin
            state_r <= ST_DONE;
          end else begin
            rd_r    <= '{valid: 1'b1, addr: tbl_w[31:0]};
            cnt_r   <= `BIDC_ENT_BYTES;
            idx_r   <= 24'h00_0000;
            sum_r   <= 8'h00;
            prev_r  <= 7'h00;
            pend_r  <= `BIDC_C_OK;
            state_r <= ST_ENT;
          end
        end
        ST_ENT: begin
          // entry bytes feed the table sum
          if (stor_ack) begin
            raw_r     <= {stor_data, raw_r[127:8]};
            sum_r     <= sum_r + stor_data;
            rd_r.addr <= rd_r.addr + 32'h0000_0001;
            cnt_r     <= cnt_r - 28'h000_0001;
            if (cnt_r == 28'h000_0001) begin
              rd_r.valid <= 1'b0;
              state_r    <= ST_EWAIT;
            end
          end
        end
        ST_EWAIT: state_r <= ST_EVENT;
        ST_EVENT: begin
          if (fin_w) begin
            state_r <= ST_DONE;
          end else begin
            if (soft_w && pend_r == `BIDC_C_OK) begin
              pend_r <= scode_w;
            end
            prev_r <= dec_ent.kind;
            idx_r  <= idx_r + 24'h00_0001;
            if (hdr_w) begin
              nent_r   <= dec_ent.size;
              hdr_cv_r <= dec_ent.cv;
            end
            if (idx_r == 24'h00_0001) begin
              late_r     <= dec_ent;
              late_len_r <= dec_len;
            end
            if (last_w) begin
              state_r <= ST_TSUM;
            end else begin
              rd_r.valid <= 1'b1;
              cnt_r      <= `BIDC_ENT_BYTES;
              state_r    <= ST_ENT;
            end
          end
        end
        ST_TSUM: begin
          if (retry_w) begin
            use_alt_r <= 1'b1;
            state_r   <= ST_EVPTR;
          end else if (fin_w) begin
            state_r <= ST_DONE;
          end else begin
            rd_r    <= '{valid: 1'b1, addr: late_r.addr[31:0]};
            cnt_r   <= late_len_r;
            sum_r   <= late_r.chk;
            state_r <= ST_COMP;
          end
        end
        ST_COMP: begin
          if (stor_ack) begin
            sum_r     <= sum_r + stor_data;
            rd_r.addr <= rd_r.addr + 32'h0000_0001;
            cnt_r     <= cnt_r - 28'h000_0001;
            if (cnt_r == 28'h000_0001) begin
              rd_r.valid <= 1'b0;
              state_r    <= ST_DONE;
            end
          end
        end
        ST_DONE: state_r <= ST_DONE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_r <= 1'b0;
      err_r  <= 1'b0;
      code_r <= `BIDC_C_OK;
    end else if (fin_w && !done_r) begin
      done_r <= 1'b1;
      err_r  <= (fin_code_w != `BIDC_C_OK);
      code_r <= fin_code_w;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prot_r <= 32'h0000_0000;
    end else if (state_r == ST_EVPTR) begin
      prot_r <= (early_w.addr[31:0] - ptr_r[287:256]) +
                {4'h0, early_w.size, 4'h0} + `BIDC_PROT_EXTRA;
    end
  end

  // Register writes
  assign s_axi_awready = !aw_hold_r && !bvalid_r;
  assign s_axi_wready  = !w_hold_r && !bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      awaddr_r  <= 8'h00;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= `BIDC_RESP_OKAY;
      start_r   <= 1'b0;
      csum_en_r <= 1'b1;
    end else begin
      start_r <= 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (aw_hold_r && w_hold_r) begin
        aw_hold_r <= 1'b0;
        w_hold_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= `BIDC_RESP_OKAY;
        if (awaddr_r == `BIDC_REG_CTRL) begin
          if (wstrb_r[0]) begin
            start_r   <= wdata_r[`BIDC_CTRL_START] && !done_r;
            csum_en_r <= wdata_r[`BIDC_CTRL_CSUM];
          end
        end else begin
          bresp_r <= `BIDC_RESP_SLVERR;
        end
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // Register reads
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= `BIDC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_r <= 1'b1;
      rresp_r  <= `BIDC_RESP_OKAY;
      case (s_axi_araddr)
        `BIDC_REG_CTRL:   rdata_r <= {30'h0, csum_en_r, 1'b0};
        `BIDC_REG_STATUS: rdata_r <= {16'h0, code_r, 4'h0, use_alt_r,
                                      err_r, done_r,
                                      state_r != ST_IDLE && !done_r};
        `BIDC_REG_ENTRY:  rdata_r <= ptr_r[287:256];
        `BIDC_REG_TABLE:  rdata_r <= tbl_w[31:0];
        `BIDC_REG_LBASE:  rdata_r <= late_r.addr[31:0];
        `BIDC_REG_LLEN:   rdata_r <= {4'h0, late_len_r};
        `BIDC_REG_LVER:   rdata_r <= {16'h0, late_r.version};
        `BIDC_REG_PROT:   rdata_r <= prot_r;
        `BIDC_REG_COUNT:  rdata_r <= {8'h0, idx_r};
        default: begin
          rdata_r <= 32'h0000_0000;
          rresp_r <= `BIDC_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_region;
    rd_r.valid |-> rd_r.addr[31:24] == 8'hFF;
  endproperty
  a_region: assert property (p_region)
    else $error("read outside firmware region");

  property p_hold_req;
    rd_r.valid && !stor_ack |=> rd_r.valid && $stable(rd_r.addr);
  endproperty
  a_hold_req: assert property (p_hold_req)
    else $error("read request changed before acknowledge");

  property p_done_hold;
    done_r |=> done_r && $stable(code_r) && $stable(err_r);
  endproperty
  a_done_hold: assert property (p_done_hold)
    else $error("outcome changed after done");

  property p_sum_code;
    state_r == ST_TSUM && sum_bad_w && (use_alt_r || alt_w == 64'h0)
      |=> done_r && code_r == 8'h02;
  endproperty
  a_sum_code: assert property (p_sum_code)
    else $error("table checksum failure not coded 2");

  property p_alt;
    state_r == ST_TSUM && sum_bad_w && !use_alt_r && alt_w != 64'h0
      |=> use_alt_r && state_r == ST_EVPTR && !done_r;
  endproperty
  a_alt: assert property (p_alt)
    else $error("alternate table not taken");

  property p_missing;
    state_r == ST_EVENT && idx_r == 24'h00_0001 &&
      dec_ent.kind != 7'h01 |=> code_r == 8'h06 && err_r;
  endproperty
  a_missing: assert property (p_missing)
    else $error("missing late entry not coded 6");

  property p_align;
    state_r == ST_EVENT && idx_r == 24'h00_0001 &&
      dec_ent.kind == 7'h01 && dec_ent.addr[14:0] != 15'h0
      |=> code_r == 8'h08 ##1 state_r == ST_DONE;
  endproperty
  a_align: assert property (p_align)
    else $error("unaligned late firmware not flagged");

  property p_order;
    state_r == ST_EVENT && !fin_w && !dec_rsvd &&
      dec_ent.kind < prev_r |=> pend_r != 8'h00;
  endproperty
  a_order: assert property (p_order)
    else $error("type decrease not flagged");
endmodule : bidc_top

// ===== bidc_stor_model.sv
// Firmware storage model answering byte reads
`timescale 1ns/1ps
module bidc_stor_model
  import bidc_pkg::*;
(
  // Clock and reset
  input  logic         aclk,
  input  logic         aresetn,
  // Byte read port
  input  bidc_rd_req_s stor_rd,
  output logic         stor_ack,
  output logic [7:0]   stor_data
);
  logic [7:0] mem [logic [31:0]];
  logic [7:0] data_r;
  logic [1:0] wait_r;
  int         n_out = 0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stor_ack <= 1'b0;
      wait_r   <= 2'h0;
    end else if (stor_rd.valid && !stor_ack && wait_r != 2'h0) begin
      wait_r <= wait_r - 2'h1;
    end else if (stor_rd.valid && !stor_ack) begin
      stor_ack <= 1'b1;
      data_r   <= mem.exists(stor_rd.addr) ? mem[stor_rd.addr] : 8'h00;
      wait_r   <= 2'($urandom);
    end else begin
      stor_ack <= 1'b0;
    end
  end

  // Stale data never repeats outside an answer
  assign stor_data = stor_ack ? data_r : ~data_r;

  always_ff @(posedge aclk) begin
    if (aresetn && stor_rd.valid && stor_rd.addr[31:24] != 8'hFF) begin
      n_out <= n_out + 1;
    end
  end
endmodule : bidc_stor_model

// ===== test_boot_image_directory_checker.sv
// Self-checking bench for the directory checker
`timescale 1ns/1ps
`include "bidc_defs.svh"
module test_boot_image_directory_checker
  import bidc_pkg::*;
;
  logic         aclk = 1'b0, aresetn = 1'b0;
  logic         awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic         awr, wr, bv, arr, rv, stor_ack;
  logic [7:0]   awa = 8'h00, ara = 8'h00, stor_data;
  logic [31:0]  wd = 32'h0, rd, d;
  logic [1:0]   bresp, rresp, r;
  bidc_rd_req_s stor_rd;
  logic [15:0]  ver;
  int           n_errors = 0, n_compared = 0, cyc = 0, n;

  bidc_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bresp),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
    .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rd),
    .s_axi_rresp(rresp), .stor_rd(stor_rd), .stor_ack(stor_ack),
    .stor_data(stor_data));
  bidc_stor_model stor (.aclk(aclk), .aresetn(aresetn), .stor_rd(stor_rd),
    .stor_ack(stor_ack), .stor_data(stor_data));

  always #4 aclk = ~aclk;

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_errors++;
      stop_test();
    end
  end

  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    awa <= a; wd <= v; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
    do begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end while (bv !== 1'b1);
    r = bresp;
    br <= 1'b0;
    // Let an edge pass before the next request
    @(posedge aclk);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a);
    ara <= a; arv <= 1'b1; rr <= 1'b1;
    do begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
    end while (rv !== 1'b1);
    d = rd;
    r = rresp;
    rr <= 1'b0;
    @(posedge aclk);
  endtask : axi_rd

  task automatic put64(input logic [31:0] a, input logic [63:0] v);
    for (int i = 0; i < 8; i++) stor.mem[a + i] = v[8*i +: 8];
  endtask : put64

  // Little-endian entry: address, size, reserved, version, flag+type, sum
  task automatic entry(input logic [31:0] a, input logic [63:0] b,
                       input logic [23:0] sz, input logic [7:0] ty,
                       input logic [7:0] cs, input logic [7:0] rs);
    put64(a, b);
    put64(a + 8, {cs, ty, ver, rs, sz});
  endtask : entry

  task automatic table_at(input logic [31:0] t, input logic [31:0] lb,
                          input logic [7:0] lty, input logic [7:0] t3,
                          input logic [7:0] t4, input logic [7:0] lcs,
                          input int f);
    logic [7:0] s;
    s = 8'h00;
    entry(t, `BIDC_SIG ^ 64'(f == 1), 24'h4, {f != 6, 7'h00}, 8'h00, 8'h00);
    entry(t + 16, {32'h0, lb}, 24'h2, {f != 4, lty[6:0]}, lcs, 8'h00);
    entry(t + 32, 64'hFFD0_0000, 24'h1, t3, 8'h5A, 8'((f == 3) ? 1 : 0));
    entry(t + 48, 64'hFFD0_0100, 24'h1, t4, 8'hA5, 8'h00);
    for (int i = 0; i < 64; i++) s += stor.mem[t + i];
    stor.mem[t + 15] = -s;
  endtask : table_at

  // Build an image, start the walk, compare the outcome
  task automatic run(input logic [7:0] code, input logic bad, input logic alt,
                     input logic [31:0] lb, input logic [7:0] lty,
                     input logic [7:0] t3, input logic [7:0] t4, input int f);
    logic [7:0] s, b;
    logic       used;
    int         t;
    s = 8'h00;
    used = bad && alt;
    stor.mem.delete();
    ver = 16'($urandom);
    for (int i = 0; i < 32; i++) begin
      b = 8'($urandom);
      stor.mem[lb + i] = b;
      s += b;
    end
    for (int i = 0; i < 16; i++) stor.mem[32'hFFFF_FFF0 + i] = 8'h90;
    put64(32'hFFFF_FFC0, 64'h0);
    put64(32'hFFFF_FFC8, alt ? 64'hFFF1_0000 : 64'h0);
    entry(32'hFFFF_FFD0, 64'hFFFF_FF00, 24'h0C, 8'h0F, 8'h00, 8'h00);
    put64(32'hFFFF_FFE0, 64'hFFF0_0000);
    put64(32'hFFFF_FFE8, 64'hFFFF_FE00);
    table_at(32'hFFF0_0000, lb, lty, t3, t4,
             -s + 8'(f inside {2, 4, 5}), f);
    if (alt) table_at(32'hFFF1_0000, lb, lty, t3, t4, -s, f);
    if (bad) stor.mem[32'hFFF0_0020] ^= 8'h01;
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_wr(`BIDC_REG_CTRL, (f == 5) ? 32'h1 : 32'h3);
    t = 0;
    do begin
      axi_rd(`BIDC_REG_STATUS);
      t++;
    end while (d[1] !== 1'b1 && t < 3000);
    chk(d, {16'h0, code, 8'h02} | (code ? 4 : 0) | (used ? 8 : 0));
    if (code == 8'h00) begin
      axi_rd(`BIDC_REG_ENTRY);
      chk(d, 32'hFFFF_FE00);
      axi_rd(`BIDC_REG_TABLE);
      chk(d, used ? 32'hFFF1_0000 : 32'hFFF0_0000);
      axi_rd(`BIDC_REG_LBASE);
      chk(d, lb);
      axi_rd(`BIDC_REG_LLEN);
      chk(d, 32'd32);
      axi_rd(`BIDC_REG_LVER);
      chk(d, {16'h0, ver});
      axi_rd(`BIDC_REG_PROT);
      chk(d, 32'h100 + 32'hC0 + 32'd64);
      axi_rd(`BIDC_REG_COUNT);
      chk(d, 32'h4);
    end
    chk(stor.n_out, 32'h0);
    $display("test done code %h", code);
  endtask : run

  initial begin
    n = $urandom(32432);
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_rd(`BIDC_REG_CTRL);
    chk(d, 32'h2);
    axi_rd(8'h40);
    chk({r, d}, {2'h2, 32'h0});
    axi_wr(8'h40, 32'h1);
    chk(r, 2'h2);
    run(8'h00, 0, 0, 32'hFFE0_0000, 1, 8'h10, 8'h10, 0);
    run(8'h00, 1, 1, 32'hFFE0_0000, 1, 8'h10, 8'h7E, 0);
    run(8'h02, 1, 0, 32'hFFE0_0000, 1, 8'h10, 8'h10, 0);
    run(8'h08, 0, 0, 32'hFFE0_4000, 1, 8'h10, 8'h10, 0);
    run(8'h10, 0, 0, 32'hFFE0_0000, 1, 8'h11, 8'h10, 0);
    run(8'h13, 0, 0, 32'hFFE0_0000, 1, 8'h05, 8'h10, 0);
    run(8'h03, 0, 0, 32'hFFE0_0000, 1, 8'h10, 8'h10, 2);
    run(8'h06, 0, 0, 32'hFFE0_0000, 8'h10, 8'h10, 8'h10, 0);
    run(8'h01, 0, 0, 32'hFFE0_0000, 1, 8'h10, 8'h10, 1);
    run(8'h11, 0, 0, 32'hFFE0_0000, 1, 8'h10, 8'h10, 3);
    run(8'h00, 0, 0, 32'hFFE0_0000, 1, 8'h10, 8'h10, 4);
    run(8'h00, 0, 0, 32'hFFE0_0000, 1, 8'h10, 8'h10, 5);
    run(8'h00, 1, 0, 32'hFFE0_0000, 1, 8'h10, 8'h10, 6);
    stop_test();
  end
endmodule : test_boot_image_directory_checker
